/* File: shared/pio_pkg.sv */
// Purpose: Constants for the programmable I/O port bank
// Assumes: Eleven byte-wide ports, some with unbonded bits
// Notes: Bit n of a flat vector is port n/8, bit n%8
package pio_pkg;
  localparam int PIO_NUM_PORTS = 11;
  localparam int PIO_PORT_W = 8;
  localparam int PIO_TOTAL_W = PIO_NUM_PORTS * PIO_PORT_W;
  localparam int PIO_PU_GROUP = 4;
  localparam int PIO_PU_GROUPS = PIO_TOTAL_W / PIO_PU_GROUP;
  localparam int PIO_IDX_W = 4;
  localparam logic [PIO_IDX_W-1:0] PIO_PORT_ONE = 4'h1;
  localparam logic [PIO_IDX_W-1:0] PIO_PORT_FIVE = 4'h5;
  localparam logic [PIO_IDX_W-1:0] PIO_PORT_NINE = 4'h9;
  localparam logic [PIO_IDX_W-1:0] PIO_PORT_LAST = 4'hA;
  localparam logic [PIO_PORT_W-1:0] PIO_RD_NONE = 8'h00;
  localparam logic [PIO_PORT_W-1:0] PIO_DIR_RESET = 8'h00;
  localparam logic [PIO_PORT_W-1:0] PIO_LAT_RESET = 8'h00;
  // Bonded pins per port, port 10 in the top byte; 78 in total
  localparam logic [PIO_TOTAL_W-1:0] PIO_PIN_MASK = {
    8'hFF, 8'h1F, 8'hCC, 8'hFF, 8'h8F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
endpackage : pio_pkg

/* File: hw/pio_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk
// Notes: Level moves only when stages two and three agree
`timescale 1ns/1ps
module pio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule : pio_sync

/* File: hw/pio_ports.sv */
// Purpose: Bank of programmable I/O ports with pull-up control
// Assumes: Single ref_clk domain; registers reached through plain ports
// Notes: Pin outputs change one cycle after the access that causes them
`timescale 1ns/1ps
//
// Contract
// - Seventy-eight pins, each with its own direction bit
// - Direction bits map one to one onto pins
// - Peripheral outputs drive regardless of direction bit
// - Port nine direction writes need protection permission
// - Output pin reads return the latch
// - Input pin reads return sampled pin level
// - Output pin writes update latch and drive
// - Input pin writes update latch, pin floats
// - Pull-ups enabled per group of four bits
// - Pull-up only connected while pin is input
// - Expansion modes disable pull-ups of ports zero-five
// - Port-control bit forces port one latch reads
// - Port one selection valid only in listed modes
module pio_ports import pio_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register access
  input wire logic [PIO_IDX_W-1:0] acc_sel,
  input wire logic acc_wr_dir,
  input wire logic acc_wr_latch,
  input wire logic [PIO_PORT_W-1:0] acc_wdata,
  input wire logic [PIO_IDX_W-1:0] rd_sel,
  output logic [PIO_PORT_W-1:0] rd_data_q,
  // Configuration
  input wire logic dir9_write_permit,
  input wire logic [PIO_PU_GROUPS-1:0] pull_group_en,
  input wire logic mem_expansion_mode,
  input wire logic microprocessor_mode,
  input wire logic ext_bus_8bit,
  input wire logic port_one_mux_port,
  input wire logic port_one_latch_read,
  // Built-in peripheral outputs (converter excluded)
  input wire logic [PIO_TOTAL_W-1:0] periph_out_en,
  input wire logic [PIO_TOTAL_W-1:0] periph_out_val,
  // Pins
  input wire logic [PIO_TOTAL_W-1:0] pin_in,
  output logic [PIO_TOTAL_W-1:0] pin_out_q,
  output logic [PIO_TOTAL_W-1:0] pin_oe_q,
  output logic [PIO_TOTAL_W-1:0] pin_pull_q
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [PIO_PORT_W-1:0] port_slice(
    input logic [PIO_TOTAL_W-1:0] vec,
    input logic [PIO_IDX_W-1:0] idx
  );
    logic [PIO_PORT_W-1:0] res;
    res = PIO_RD_NONE;
    for (int p = 0; p < PIO_NUM_PORTS; p++) begin
      if (idx == PIO_IDX_W'(p)) begin
        res = vec[p*PIO_PORT_W +: PIO_PORT_W];
      end
    end
    return res;
  endfunction : port_slice

  ////////////////////////////////////////////////////////////////////////
  logic [PIO_TOTAL_W-1:0] dir_q;
  logic [PIO_TOTAL_W-1:0] dir_d;
  logic [PIO_TOTAL_W-1:0] lat_q;
  logic [PIO_TOTAL_W-1:0] lat_d;
  logic [PIO_TOTAL_W-1:0] pin_out_d;
  logic [PIO_TOTAL_W-1:0] pin_oe_d;
  logic [PIO_TOTAL_W-1:0] pin_pull_d;
  logic [PIO_PORT_W-1:0] rd_data_d;
  logic [PIO_TOTAL_W-1:0] pin_level;
  logic ext_mode;
  logic p1_select_valid;

  pio_sync #(
    .WIDTH(PIO_TOTAL_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(pin_in),
    .level_q(pin_level)
  );

  assign ext_mode = mem_expansion_mode | microprocessor_mode;
  assign p1_select_valid = (ext_mode & ext_bus_8bit) | port_one_mux_port;

  ////////////////////////////////////////////////////////////////////////
  // Direction and latch registers
  always_comb begin
    dir_d = dir_q;
    lat_d = lat_q;
    for (int p = 0; p < PIO_NUM_PORTS; p++) begin
      if (acc_sel == PIO_IDX_W'(p)) begin
        // Unbonded bits stay zero
        if (acc_wr_dir &&
            (acc_sel != PIO_PORT_NINE || dir9_write_permit)) begin
          dir_d[p*PIO_PORT_W +: PIO_PORT_W] = acc_wdata &
            PIO_PIN_MASK[p*PIO_PORT_W +: PIO_PORT_W];
        end
        // Latch takes writes in either direction
        if (acc_wr_latch) begin
          lat_d[p*PIO_PORT_W +: PIO_PORT_W] = acc_wdata &
            PIO_PIN_MASK[p*PIO_PORT_W +: PIO_PORT_W];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_q <= {PIO_NUM_PORTS{PIO_DIR_RESET}};
      lat_q <= {PIO_NUM_PORTS{PIO_LAT_RESET}};
    end else begin
      dir_q <= dir_d;
      lat_q <= lat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers and pull-ups
  always_comb begin
    pin_oe_d = (dir_d | periph_out_en) & PIO_PIN_MASK;
    pin_out_d = ((periph_out_en & periph_out_val) |
                 (~periph_out_en & lat_d)) & PIO_PIN_MASK;
    pin_pull_d = '0;
    for (int b = 0; b < PIO_TOTAL_W; b++) begin
      if (pull_group_en[b / PIO_PU_GROUP] && !pin_oe_d[b] &&
          PIO_PIN_MASK[b] &&
          !(ext_mode &&
            (b / PIO_PORT_W) <= int'(PIO_PORT_FIVE))) begin
        pin_pull_d[b] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe_q <= '0;
      pin_out_q <= '0;
      pin_pull_q <= '0;
    end else begin
      pin_oe_q <= pin_oe_d;
      pin_out_q <= pin_out_d;
      pin_pull_q <= pin_pull_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; the answer shows one cycle after rd_sel
  always_comb begin
    logic [PIO_PORT_W-1:0] dsel;
    logic [PIO_PORT_W-1:0] lsel;
    logic [PIO_PORT_W-1:0] psel;
    dsel = port_slice(dir_q, rd_sel);
    lsel = port_slice(lat_q, rd_sel);
    psel = port_slice(pin_level, rd_sel);
    rd_data_d = (dsel & lsel) | (~dsel & psel);
    if (rd_sel == PIO_PORT_ONE && port_one_latch_read &&
        p1_select_valid) begin
      rd_data_d = lsel;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= PIO_RD_NONE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_DIR9_LOCKED: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (acc_wr_dir && acc_sel == PIO_PORT_NINE && !dir9_write_permit)
    |=> $stable(dir_q[9*PIO_PORT_W +: PIO_PORT_W]))
    else $error("Port nine direction changed without permit");

  AST_DIR9_OPEN: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (acc_wr_dir && acc_sel == PIO_PORT_NINE && dir9_write_permit)
    |=> dir_q[9*PIO_PORT_W +: PIO_PORT_W] ==
        ($past(acc_wdata) & PIO_PIN_MASK[9*PIO_PORT_W +: PIO_PORT_W]))
    else $error("Permitted port nine direction write lost");

  AST_OE_FOLLOWS_DIR: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ##1 pin_oe_q == (($past(dir_d) | $past(periph_out_en)) & PIO_PIN_MASK))
    else $error("Output enable does not follow direction");

  AST_PERIPH_DRIVES: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    periph_out_en[0]
    |=> pin_oe_q[0] && pin_out_q[0] == $past(periph_out_val[0]))
    else $error("Peripheral output not driven");

  AST_INPUT_FLOATS: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (acc_wr_latch && acc_sel == PIO_PORT_LAST && dir_d[80] == 1'b0 &&
     !periph_out_en[80]) |=> !pin_oe_q[80])
    else $error("Input pin driven after latch write");

  AST_READ_OUTPUT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_sel == PIO_PORT_LAST && dir_q[80])
    |=> rd_data_q[0] == $past(lat_q[80]))
    else $error("Output pin read did not return latch");

  AST_READ_INPUT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_sel == PIO_PORT_LAST && !dir_q[80])
    |=> rd_data_q[0] == $past(pin_level[80]))
    else $error("Input pin read did not return pin level");

  AST_PULL_OFF_OUTPUT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (pin_oe_q & pin_pull_q) == '0)
    else $error("Pull-up connected on driven pin");

  AST_PULL_EXT_MODE: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ext_mode |=> pin_pull_q[47:0] == '0)
    else $error("Pull-up active on ports zero to five in expansion mode");

  AST_PORT_ONE_LATCH: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_sel == PIO_PORT_ONE && port_one_latch_read && p1_select_valid)
    |=> rd_data_q == $past(lat_q[15:8]))
    else $error("Port one latch read selection ignored");

  AST_RESET_INPUT: assert property (
    @(posedge ref_clk)
    !rst_b |=> pin_oe_q == '0 || !rst_b || $past(periph_out_en) != '0 ||
               $past(dir_q) != '0)
    else $error("Pin driven straight after reset");

  ////////////////////////////////////////////////////////////////////////
  // Unbonded-bit check on the whole bank, then checks on the top port; its byte is fully bonded, so no mask games
  localparam int TOP_LO = int'(PIO_PORT_LAST) * PIO_PORT_W;

  AST_UNBONDED_QUIET: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ((pin_oe_q | pin_out_q | pin_pull_q) & ~PIO_PIN_MASK) == '0)
    else $error("Unbonded bit drives or pulls");

  AST_DIR_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (acc_wr_dir && acc_sel == PIO_PORT_LAST)
    |=> dir_q[TOP_LO +: PIO_PORT_W] == $past(acc_wdata))
    else $error("Direction write did not land");

  AST_LATCH_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (acc_wr_latch && acc_sel == PIO_PORT_LAST)
    |=> lat_q[TOP_LO +: PIO_PORT_W] == $past(acc_wdata))
    else $error("Latch write did not land");

  AST_OUT_FOLLOWS_LATCH: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (dir_d[TOP_LO] && !periph_out_en[TOP_LO])
    |=> pin_oe_q[TOP_LO] && pin_out_q[TOP_LO] == $past(lat_d[TOP_LO]))
    else $error("Output pin does not show latch");

  AST_PULL_GROUP_OFF: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !pull_group_en[PIO_PU_GROUPS-1]
    |=> pin_pull_q[PIO_TOTAL_W-1 -: PIO_PU_GROUP] == '0)
    else $error("Pull-up on while its group is off");

  // Outside the listed modes the control bit must not hide the pin
  AST_PORT_ONE_PIN: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_sel == PIO_PORT_ONE && !p1_select_valid && !dir_q[PIO_PORT_W])
    |=> rd_data_q[0] == $past(pin_level[PIO_PORT_W]))
    else $error("Port one read ignored pin outside listed modes");
endmodule : pio_ports

/* File: testbench/pio_pin_model.sv */
// Purpose: External devices on the port pins
// Assumes: Bench picks which pins an outside device drives
// Notes: A bare floating pin toggles so no stale level reads back
`timescale 1ns/1ps
module pio_pin_model import pio_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Bank side
  input wire logic [PIO_TOTAL_W-1:0] pin_out,
  input wire logic [PIO_TOTAL_W-1:0] pin_oe,
  input wire logic [PIO_TOTAL_W-1:0] pin_pull,
  // Outside drivers
  input wire logic [PIO_TOTAL_W-1:0] ext_en,
  input wire logic [PIO_TOTAL_W-1:0] ext_val,
  output logic [PIO_TOTAL_W-1:0] pin_in
);
  logic [PIO_TOTAL_W-1:0] last_q = '0;
  logic [PIO_TOTAL_W-1:0] idle;
  // Bank drive first, then device, then pull-up, else toggling
  always_comb begin
    idle = ~pin_oe & ~ext_en;
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (idle & pin_pull) | (idle & ~pin_pull & ~last_q);
  end
  always @(posedge ref_clk) last_q <= pin_in;
endmodule : pio_pin_model

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the I/O port bank
// Assumes: Inputs change on the falling edge
// Notes: Reads wait 8 cycles so the pin synchroniser settles
`timescale 1ns/1ps
module testbench import pio_pkg::*;;
  typedef struct {int p; logic [7:0] dir, lat, ext, rd, oe, out;} pio_row_type;
  logic ref_clk, rst_b, acc_wr_dir, acc_wr_latch, dir9_write_permit;
  logic [3:0] acc_sel, rd_sel;
  logic [7:0] acc_wdata, rd_data_q, got;
  logic mem_expansion_mode, microprocessor_mode, ext_bus_8bit;
  logic port_one_mux_port, port_one_latch_read;
  logic [PIO_PU_GROUPS-1:0] pull_group_en;
  logic [PIO_TOTAL_W-1:0] periph_out_en, periph_out_val, pin_in, pin_out_q;
  logic [PIO_TOTAL_W-1:0] pin_oe_q, pin_pull_q, ext_en, ext_val;
  int num_errors = 0, tests_run = 0, cycles = 0;
  pio_row_type rows[5] = '{
    '{0, 8'hFF, 8'hA5, 8'h3C, 8'hA5, 8'hFF, 8'hA5},
    '{2, 8'h00, 8'h5A, 8'hC3, 8'hC3, 8'h00, 8'h5A},
    '{3, 8'h0F, 8'h33, 8'hCC, 8'hC3, 8'h0F, 8'h33},
    '{6, 8'hFF, 8'hFF, 8'h00, 8'h8F, 8'h8F, 8'h8F},
    '{8, 8'h0F, 8'hFF, 8'hF0, 8'hFC, 8'h0C, 8'hCC}};
  // Mode bits: latch_read, mem, micro, bus8, mux; last bit latch expected
  logic [5:0] modes[6] = '{6'h20, 6'h23, 6'h35, 6'h2D, 6'h30, 6'h02};
  pio_ports DUT (.ref_clk, .rst_b, .acc_sel, .acc_wr_dir, .acc_wr_latch,
    .acc_wdata, .rd_sel, .rd_data_q, .dir9_write_permit, .pull_group_en,
    .mem_expansion_mode, .microprocessor_mode, .ext_bus_8bit,
    .port_one_mux_port, .port_one_latch_read, .periph_out_en,
    .periph_out_val, .pin_in, .pin_out_q, .pin_oe_q, .pin_pull_q);
  pio_pin_model PINS (.ref_clk, .pin_out(pin_out_q), .pin_oe(pin_oe_q),
    .pin_pull(pin_pull_q), .ext_en, .ext_val, .pin_in);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One write per call; dir and latch share the data byte
  task automatic wr(logic [3:0] s, logic [7:0] d, logic [1:0] m);
    @(negedge ref_clk);
    {acc_sel, acc_wdata, acc_wr_dir, acc_wr_latch} = {s, d, m};
    @(negedge ref_clk);
    {acc_wr_dir, acc_wr_latch} = 2'b00;
  endtask : wr
  task automatic rd(logic [3:0] s);
    rd_sel = s;
    repeat (8) @(negedge ref_clk);
    got = rd_data_q;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, acc_wr_dir, acc_wr_latch, dir9_write_permit} = '0;
    {acc_sel, rd_sel, acc_wdata, pull_group_en} = '0;
    {mem_expansion_mode, microprocessor_mode, ext_bus_8bit} = '0;
    {port_one_mux_port, port_one_latch_read} = '0;
    {periph_out_en, periph_out_val, ext_en, ext_val} = '0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk("oe_after_reset", 8'h00, 8'(|pin_oe_q));
    foreach (rows[i]) begin
      ext_en[8*rows[i].p +: 8] = ~rows[i].oe;
      ext_val[8*rows[i].p +: 8] = rows[i].ext;
      wr(4'(rows[i].p), rows[i].dir, 2'b10);
      wr(4'(rows[i].p), rows[i].lat, 2'b01);
      rd(4'(rows[i].p));
      chk("rd_data", rows[i].rd, got);
      chk("pin_oe", rows[i].oe, pin_oe_q[8*rows[i].p +: 8]);
      chk("pin_out", rows[i].out, pin_out_q[8*rows[i].p +: 8]);
    end
    wr(4'h9, 8'hFF, 2'b10);
    chk("oe_p9_locked", 8'h00, pin_oe_q[79:72]);
    dir9_write_permit = 1'b1;
    wr(4'h9, 8'hFF, 2'b10);
    chk("oe_p9_open", 8'h1F, pin_oe_q[79:72]);
    dir9_write_permit = 1'b0;
    wr(4'h9, 8'h00, 2'b10);
    chk("oe_p9_kept", 8'h1F, pin_oe_q[79:72]);
    {periph_out_en[56], periph_out_val[56]} = 2'b11;
    repeat (2) @(negedge ref_clk);
    chk("oe_periph", 8'h01, pin_oe_q[63:56]);
    chk("out_periph", 8'h01, pin_out_q[63:56]);
    periph_out_en[56] = 1'b0;
    pull_group_en = 22'h100000;
    repeat (2) @(negedge ref_clk);
    chk("pull_group", 8'h0F, pin_pull_q[87:80]);
    pull_group_en = '1;
    wr(4'hA, 8'hF0, 2'b10);
    chk("pull_in_only", 8'h0F, pin_pull_q[87:80]);
    chk("pull_p2", 8'hFF, pin_pull_q[23:16]);
    mem_expansion_mode = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("pull_exp_p2", 8'h00, pin_pull_q[23:16]);
    chk("pull_exp_p7", 8'hFF, pin_pull_q[63:56]);
    {mem_expansion_mode, microprocessor_mode} = 2'b01;
    repeat (2) @(negedge ref_clk);
    chk("pull_micro_p2", 8'h00, pin_pull_q[23:16]);
    microprocessor_mode = 1'b0;
    ext_en[15:8] = 8'hFF;
    ext_val[15:8] = 8'hA5;
    wr(4'h1, 8'h5A, 2'b01);
    foreach (modes[i]) begin
      {port_one_latch_read, mem_expansion_mode, microprocessor_mode,
        ext_bus_8bit, port_one_mux_port} = modes[i][5:1];
      rd(4'h1);
      chk("rd_port_one", modes[i][0] ? 8'h5A : 8'hA5, got);
    end
    report_and_stop();
  end
endmodule : testbench
